//--- core/tmir_top.sv
// Timer mode control and input routing block with its register port
//
// Contract
// - Input switch register resets to zero
// - Capture input from own pin or serial receive
// - Pin pair: 00 default, 10 alternate only
// - Gate enable gates channel 2 events
// - Interrupt zero from own pin or serial receive
// - Routed serial receive uses selected pin pair
// - Three channels: counter, compare, timer output
// - Channel 2 counts events, cascades to wide timer
// - Mode control registers reset to zero
// - Count enable zero clears and stops counter
// - Level field: keep, clear, set; 11 banned
// - Level set and clear bits read zero
// - Registers take bit and byte writes
`include "tmir_defs.svh"

module tmir_top #(
   parameter int NCH = 3,
   parameter int WIDTH = 8
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [15:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic bus_wr_i,
   input wire logic bus_bit_i,
   input wire logic [2:0] bus_bit_sel_i,
   input wire logic bus_rd_i,
   output logic [7:0] bus_rdata_o,
   input wire logic capture_event_input_i,
   input wire logic external_irq_zero_i,
   input wire logic serial_receive_line_dflt_i,
   input wire logic serial_receive_line_alt_i,
   input wire logic serial_transmit_line_i,
   input wire logic [NCH-1:0] channel_timer_input_i,
   input wire logic gating_timer_output_i,
   input wire logic [NCH-1:0] count_tick_i,
   input wire logic ch2_event_mode_i,
   output logic capture_event_o,
   output logic external_irq_zero_o,
   output logic serial_receive_line_o,
   output logic serial_transmit_line_dflt_o,
   output logic serial_transmit_line_alt_o,
   output logic [NCH-1:0] channel_out_o,
   output logic [NCH-1:0] channel_match_o,
   output logic cascade_carry_o
);

   // ----------------------------------------
   // Address decode helpers
   // ----------------------------------------
   function automatic logic [15:0] mode_addr(input int n);
      case (n)
         0: mode_addr = `TMIR_TMC0_ADDR;
         1: mode_addr = `TMIR_TMC1_ADDR;
         default: mode_addr = `TMIR_TMC2_ADDR;
      endcase
   endfunction

   function automatic logic [15:0] cmp_addr(input int n);
      case (n)
         0: cmp_addr = `TMIR_CMP0_ADDR;
         1: cmp_addr = `TMIR_CMP1_ADDR;
         default: cmp_addr = `TMIR_CMP2_ADDR;
      endcase
   endfunction

   function automatic logic [15:0] cnt_addr(input int n);
      case (n)
         0: cnt_addr = `TMIR_CNT0_ADDR;
         1: cnt_addr = `TMIR_CNT1_ADDR;
         default: cnt_addr = `TMIR_CNT2_ADDR;
      endcase
   endfunction

   // Byte write, or one bit replaced in the old value
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                        input logic bitm, input logic [2:0] sel);
      logic [7:0] r;
      r = wd;
      if (bitm) begin
         r = old;
         r[sel] = wd[sel];
      end
      merge = r;
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] isc_ff;
   logic [7:0] mode_ff [NCH];
   logic [WIDTH-1:0] cmp_ff [NCH];
   logic [WIDTH-1:0] count_w [NCH];
   logic [NCH-1:0] lvl_set_w;
   logic [NCH-1:0] lvl_clr_w;
   logic [NCH-1:0] tick_w;
   logic [NCH-1:0] out_w;
   logic [NCH-1:0] match_w;
   logic isc_wr;
   logic [7:0] nxt_isc;
   logic [7:0] nxt_rdata;

   assign isc_wr = bus_wr_i && (bus_addr_i == `TMIR_ISC_ADDR);
   assign nxt_isc = merge(isc_ff, bus_wdata_i, bus_bit_i, bus_bit_sel_i);

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         isc_ff <= `TMIR_ISC_RESET;
      end else if (isc_wr) begin
         isc_ff <= nxt_isc & `TMIR_ISC_RMASK;
      end
   end

   // ----------------------------------------
   // Per-channel mode and compare registers
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_regs
         logic mode_wr;
         logic cmp_wr;
         logic [7:0] nxt_mode;
         tmir_pkg::tmir_lvl_t lvl;

         assign mode_wr = bus_wr_i && (bus_addr_i == mode_addr(g));
         assign cmp_wr = bus_wr_i && (bus_addr_i == cmp_addr(g));
         assign nxt_mode = merge(mode_ff[g], bus_wdata_i, bus_bit_i, bus_bit_sel_i);
         assign lvl = tmir_pkg::tmir_lvl_t'({nxt_mode[`TMIR_TMC_LVS],
                                             nxt_mode[`TMIR_TMC_LVR]});
         assign lvl_set_w[g] = mode_wr && (lvl == tmir_pkg::TMIR_LVL_SET);
         assign lvl_clr_w[g] = mode_wr && (lvl == tmir_pkg::TMIR_LVL_CLEAR);

         always_ff @(posedge core_clk_i) begin
            if (!rstn_i) begin
               mode_ff[g] <= `TMIR_TMC_RESET;
            end else if (mode_wr) begin
               mode_ff[g] <= nxt_mode & `TMIR_TMC_RMASK;
            end
         end

         always_ff @(posedge core_clk_i) begin
            if (!rstn_i) begin
               cmp_ff[g] <= `TMIR_CMP_RESET;
            end else if (cmp_wr) begin
               cmp_ff[g] <= merge(cmp_ff[g], bus_wdata_i, bus_bit_i, bus_bit_sel_i);
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_comb begin
      nxt_rdata = 8'h00;
      if (bus_addr_i == `TMIR_ISC_ADDR) begin
         nxt_rdata = isc_ff;
      end
      for (int i = 0; i < NCH; i++) begin
         if (bus_addr_i == mode_addr(i)) begin
            nxt_rdata = mode_ff[i] & `TMIR_TMC_RMASK;
         end
         if (bus_addr_i == cmp_addr(i)) begin
            nxt_rdata = cmp_ff[i];
         end
         if (bus_addr_i == cnt_addr(i)) begin
            nxt_rdata = count_w[i];
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         bus_rdata_o <= 8'h00;
      end else if (bus_rd_i) begin
         bus_rdata_o <= nxt_rdata;
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic cap_s;
   logic irq_s;
   logic rxd_s;
   logic rxa_s;
   logic [NCH-1:0] ti_s;

   tmir_sync #(.WIDTH(4 + NCH)) u_sync (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .async_i({capture_event_input_i, external_irq_zero_i, serial_receive_line_dflt_i,
                serial_receive_line_alt_i, channel_timer_input_i}),
      .sync_o({cap_s, irq_s, rxd_s, rxa_s, ti_s})
   );

   // ----------------------------------------
   // Input routing
   // ----------------------------------------
   tmir_pkg::tmir_pin_pair_t pair;
   logic rx_sel;

   assign pair = tmir_pkg::tmir_pin_pair_t'({isc_ff[`TMIR_ISC_PAIR_HI],
                                             isc_ff[`TMIR_ISC_PAIR_LO]});

   // Receive line taken from the alternate pair, or from the default pair when receive enable is set; idle high otherwise
   always_comb begin
      case (pair)
         tmir_pkg::TMIR_PAIR_DEFAULT: rx_sel = rxd_s | ~isc_ff[`TMIR_ISC_RX_EN];
         tmir_pkg::TMIR_PAIR_ALT: rx_sel = rxa_s;
         default: rx_sel = 1'b1;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         capture_event_o <= 1'b0;
         external_irq_zero_o <= 1'b0;
         serial_receive_line_o <= 1'b1;
      end else begin
         capture_event_o <= isc_ff[`TMIR_ISC_CAP] ? rx_sel : cap_s;
         external_irq_zero_o <= isc_ff[`TMIR_ISC_IRQ] ? rx_sel : irq_s;
         serial_receive_line_o <= rx_sel;
      end
   end

   // ----------------------------------------
   // Transmit pin steering
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         serial_transmit_line_dflt_o <= 1'b1;
         serial_transmit_line_alt_o <= 1'b1;
      end else begin
         serial_transmit_line_dflt_o <= (pair == tmir_pkg::TMIR_PAIR_DEFAULT) ?
                                        serial_transmit_line_i : 1'b1;
         serial_transmit_line_alt_o <= (pair == tmir_pkg::TMIR_PAIR_ALT) ?
                                       serial_transmit_line_i : 1'b1;
      end
   end

   // ----------------------------------------
   // Channel 2 event input
   // ----------------------------------------
   logic ev_gated;
   logic ev_q_ff;

   assign ev_gated = ti_s[2] & (~isc_ff[`TMIR_ISC_GATE] | gating_timer_output_i);

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         ev_q_ff <= 1'b0;
      end else begin
         ev_q_ff <= ev_gated;
      end
   end

   always_comb begin
      tick_w = count_tick_i;
      tick_w[2] = ch2_event_mode_i ? (ev_gated & ~ev_q_ff) : count_tick_i[2];
   end

   // ----------------------------------------
   // Channels
   // ----------------------------------------
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         tmir_channel #(.WIDTH(WIDTH)) u_ch (
            .core_clk_i(core_clk_i),
            .rstn_i(rstn_i),
            .cnt_en_i(mode_ff[g][`TMIR_TMC_CE]),
            .inv_en_i(mode_ff[g][`TMIR_TMC_INV]),
            .lvl_set_i(lvl_set_w[g]),
            .lvl_clr_i(lvl_clr_w[g]),
            .tick_i(tick_w[g]),
            .cmp_i(cmp_ff[g]),
            .count_o(count_w[g]),
            .match_o(match_w[g]),
            .out_o(out_w[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Channel output registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         channel_out_o <= '0;
         channel_match_o <= '0;
         cascade_carry_o <= 1'b0;
      end else begin
         channel_out_o <= out_w;
         channel_match_o <= match_w;
         cascade_carry_o <= match_w[2] & ch2_event_mode_i;
      end
   end
endmodule // tmir_top

//--- core/tmir_defs.svh
// Register offsets, field positions, reset values and masks of the timer control block
`ifndef TMIR_DEFS_SVH
`define TMIR_DEFS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TMIR_ISC_ADDR 16'hFF4F
`define TMIR_TMC0_ADDR 16'hFF6B
`define TMIR_TMC1_ADDR 16'hFF43
`define TMIR_TMC2_ADDR 16'hFF44
`define TMIR_CMP0_ADDR 16'hFF45
`define TMIR_CMP1_ADDR 16'hFF46
`define TMIR_CMP2_ADDR 16'hFF47
`define TMIR_CNT0_ADDR 16'hFF48
`define TMIR_CNT1_ADDR 16'hFF49
`define TMIR_CNT2_ADDR 16'hFF4A

// ----------------------------------------
// Input switch fields
// ----------------------------------------
`define TMIR_ISC_PAIR_HI 5
`define TMIR_ISC_PAIR_LO 4
`define TMIR_ISC_RX_EN 3
`define TMIR_ISC_GATE 2
`define TMIR_ISC_CAP 1
`define TMIR_ISC_IRQ 0
`define TMIR_ISC_RMASK 8'h3F
`define TMIR_ISC_RESET 8'h00

// ----------------------------------------
// Mode control fields
// ----------------------------------------
`define TMIR_TMC_CE 7
`define TMIR_TMC_LVS 3
`define TMIR_TMC_LVR 2
`define TMIR_TMC_INV 1
`define TMIR_TMC_RMASK 8'h82
`define TMIR_TMC_RESET 8'h00
`define TMIR_CMP_RESET 8'h00

`endif

//--- core/tmir_pkg.sv
// Types shared by the timer control block
package tmir_pkg;
   typedef enum logic [1:0] {
      TMIR_PAIR_DEFAULT = 2'h0,
      TMIR_PAIR_ALT = 2'h2
   } tmir_pin_pair_t;

   typedef enum logic [1:0] {
      TMIR_LVL_KEEP = 2'h0,
      TMIR_LVL_CLEAR = 2'h1,
      TMIR_LVL_SET = 2'h2,
      TMIR_LVL_BAD = 2'h3
   } tmir_lvl_t;
endpackage

//--- core/tmir_sync.sv
// Two-stage synchroniser for pin inputs
module tmir_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         meta_ff <= '0;
         sync_o <= '0;
      end else begin
         meta_ff <= async_i;
         sync_o <= meta_ff;
      end
   end
endmodule // tmir_sync

//--- core/tmir_channel.sv
// One 8-bit up counter with compare match and timer output flip-flop
module tmir_channel #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic cnt_en_i,
   input wire logic inv_en_i,
   input wire logic lvl_set_i,
   input wire logic lvl_clr_i,
   input wire logic tick_i,
   input wire logic [WIDTH-1:0] cmp_i,
   output logic [WIDTH-1:0] count_o,
   output logic match_o,
   output logic out_o
);
   logic hit;

   assign hit = cnt_en_i && tick_i && (count_o == cmp_i);

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         count_o <= '0;
      end else if (!cnt_en_i) begin
         count_o <= '0;
      end else if (hit) begin
         count_o <= '0;
      end else if (tick_i) begin
         count_o <= count_o + WIDTH'(1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         match_o <= 1'b0;
      end else begin
         match_o <= hit;
      end
   end

   // ----------------------------------------
   // Output flip-flop
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         out_o <= 1'b0;
      end else if (lvl_set_i) begin
         out_o <= 1'b1;
      end else if (lvl_clr_i) begin
         out_o <= 1'b0;
      end else if (hit && inv_en_i) begin
         out_o <= ~out_o;
      end
   end
endmodule // tmir_channel

//--- bench/tmir_props.sv
// Checker of routing and timer output relations at the block ports
`include "tmir_defs.svh"
module tmir_props #(
   parameter int NCH = 3
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [15:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic bus_wr_i,
   input wire logic bus_bit_i,
   input wire logic [2:0] bus_bit_sel_i,
   input wire logic bus_rd_i,
   input wire logic [7:0] bus_rdata_o,
   input wire logic capture_event_input_i,
   input wire logic external_irq_zero_i,
   input wire logic serial_receive_line_dflt_i,
   input wire logic serial_receive_line_alt_i,
   input wire logic serial_transmit_line_i,
   input wire logic capture_event_o,
   input wire logic external_irq_zero_o,
   input wire logic serial_receive_line_o,
   input wire logic serial_transmit_line_dflt_o,
   input wire logic serial_transmit_line_alt_o,
   input wire logic [NCH-1:0] channel_out_o,
   input wire logic [NCH-1:0] channel_match_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // Shadow of written control bits
   // ----------------------------------------
   logic [5:0] isc_ff;
   logic inv_ff;
   logic ce_ff;
   logic [3:0] iq_ff;
   logic [3:0] tq_ff;
   logic isc_wr;
   logic tmc_wr;
   assign isc_wr = bus_wr_i && bus_addr_i == `TMIR_ISC_ADDR;
   assign tmc_wr = bus_wr_i && bus_addr_i == `TMIR_TMC0_ADDR;
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         isc_ff <= 6'h00;
      end else if (isc_wr && !bus_bit_i) begin
         isc_ff <= bus_wdata_i[5:0];
      end else if (isc_wr && bus_bit_sel_i < 3'h6) begin
         isc_ff[bus_bit_sel_i] <= bus_wdata_i[bus_bit_sel_i];
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         inv_ff <= 1'b0;
         ce_ff <= 1'b0;
      end else if (tmc_wr && (!bus_bit_i || bus_bit_sel_i == 3'h1)) begin
         inv_ff <= bus_wdata_i[1];
      end else if (tmc_wr && bus_bit_sel_i == 3'h7) begin
         ce_ff <= bus_wdata_i[7];
      end
      if (rstn_i && tmc_wr && !bus_bit_i) begin
         ce_ff <= bus_wdata_i[7];
      end
   end
   always_ff @(posedge core_clk_i) begin
      iq_ff <= (!rstn_i || isc_wr) ? 4'h0 : (iq_ff == 4'hF ? iq_ff : iq_ff + 4'h1);
      tq_ff <= (!rstn_i || tmc_wr) ? 4'h0 : (tq_ff == 4'hF ? tq_ff : tq_ff + 4'h1);
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_isc_quiet;
      iq_ff > 4'h3;
   endsequence
   sequence s_tmc_quiet;
      tq_ff > 4'h5;
   endsequence
   a_rx_pair_pick:
   assert property (s_isc_quiet |-> serial_receive_line_o == (isc_ff[5:4] == 2'h2 ?
      $past(serial_receive_line_alt_i, 3) : (isc_ff[5:3] == 3'h1 ?
      $past(serial_receive_line_dflt_i, 3) : 1'b1))) else $error("receive pin pick wrong");
   a_cap_route_sel:
   assert property (s_isc_quiet |-> capture_event_o == (isc_ff[1] ? serial_receive_line_o :
      $past(capture_event_input_i, 3))) else $error("capture route wrong");
   a_irq_route_sel:
   assert property (s_isc_quiet |-> external_irq_zero_o == (isc_ff[0] ? serial_receive_line_o :
      $past(external_irq_zero_i, 3))) else $error("interrupt route wrong");
   a_tx_pair_pick:
   assert property (s_isc_quiet |-> {serial_transmit_line_alt_o, serial_transmit_line_dflt_o} ==
      (isc_ff[5:4] == 2'h0 ? {1'b1, $past(serial_transmit_line_i)} : (isc_ff[5:4] == 2'h2 ?
      {$past(serial_transmit_line_i), 1'b1} : 2'h3))) else $error("transmit pick wrong");
   a_off_no_match:
   assert property (s_tmc_quiet ##0 !ce_ff |-> !channel_match_o[0]) else $error("match while off");
   a_out_hold_fixed:
   assert property (s_tmc_quiet ##0 !inv_ff |-> $stable(channel_out_o[0]))
      else $error("output moved without inversion");
   a_out_toggle_match:
   assert property (s_tmc_quiet ##0 inv_ff && channel_match_o[0] |->
      channel_out_o[0] != $past(channel_out_o[0], 3)) else $error("no toggle on match");
   a_lvl_reads_zero:
   assert property (bus_rd_i && bus_addr_i == `TMIR_TMC0_ADDR |=> bus_rdata_o[3:2] == 2'h0)
      else $error("level bits read nonzero");
endmodule // tmir_props

bind tmir_top tmir_props #(.NCH(NCH)) i_tmir_props (
   .core_clk_i, .rstn_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_bit_i, .bus_bit_sel_i,
   .bus_rd_i, .bus_rdata_o, .capture_event_input_i, .external_irq_zero_i,
   .serial_receive_line_dflt_i, .serial_receive_line_alt_i, .serial_transmit_line_i,
   .capture_event_o, .external_irq_zero_o, .serial_receive_line_o,
   .serial_transmit_line_dflt_o, .serial_transmit_line_alt_o, .channel_out_o, .channel_match_o
);

//--- bench/tmir_pins.sv
// Model of the external pins and the gating timer output
module tmir_pins (
   input wire logic core_clk_i,
   output logic [4:0] pins_o = 5'h1F,
   output logic [2:0] ev_o = 3'h0,
   output logic gate_o = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   task automatic drive(input logic [4:0] v, input logic g);
      @(posedge core_clk_i);
      pins_o <= v;
      gate_o <= g;
   endtask
   task automatic events(input int n);
      repeat (n) begin
         @(posedge core_clk_i);
         ev_o[2] <= 1'b1;
         repeat (4) @(posedge core_clk_i);
         ev_o[2] <= 1'b0;
         repeat (4) @(posedge core_clk_i);
      end
   endtask
endmodule // tmir_pins

//--- bench/tmir_bench.sv
// Self-checking testbench of the timer control block
`include "tmir_defs.svh"
module tmir_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rstn, wr, bt, rd, evm, gate, cap, irq, rx, txd, txa, carry;
   logic [15:0] addr;
   logic [7:0] wd, rdata, n_carry;
   logic [2:0] bs, tick, ev, chout, chm;
   logic [4:0] pins;
   logic [15:0] tma [3];
   logic [5:0] iscs [4];
   int n_mismatch, n_compared;
   tmir_top i_tmir_top (
      .core_clk_i(clk), .rstn_i(rstn), .bus_addr_i(addr), .bus_wdata_i(wd), .bus_wr_i(wr),
      .bus_bit_i(bt), .bus_bit_sel_i(bs), .bus_rd_i(rd), .bus_rdata_o(rdata),
      .capture_event_input_i(pins[0]), .external_irq_zero_i(pins[1]),
      .serial_receive_line_dflt_i(pins[2]), .serial_receive_line_alt_i(pins[3]),
      .serial_transmit_line_i(pins[4]), .channel_timer_input_i(ev),
      .gating_timer_output_i(gate), .count_tick_i(tick), .ch2_event_mode_i(evm),
      .capture_event_o(cap), .external_irq_zero_o(irq), .serial_receive_line_o(rx),
      .serial_transmit_line_dflt_o(txd), .serial_transmit_line_alt_o(txa),
      .channel_out_o(chout), .channel_match_o(chm), .cascade_carry_o(carry)
   );
   tmir_pins i_tmir_pins (.core_clk_i(clk), .pins_o(pins), .ev_o(ev), .gate_o(gate));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrb(input logic [15:0] a, input logic [7:0] d, input logic b,
      input logic [2:0] s);
      @(posedge clk);
      {addr, wd, bt, bs, wr} <= {a, d, b, s, 1'b1};
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      {addr, rd} <= {a, 1'b1};
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic ticks(input int c, input int n);
      repeat (n) begin
         @(posedge clk);
         tick[c] <= 1'b1;
         @(posedge clk);
         tick[c] <= 1'b0;
      end
   endtask
   task automatic wrap_up();
      if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [7:0] route(input logic [5:0] s, input logic [4:0] p);
      logic x;
      x = s[5:4] == 2'h2 ? p[3] : (s[5:3] == 3'h1 ? p[2] : 1'b1);
      return {3'h0, s[5:4] == 2'h2 ? p[4] : 1'b1, s[5:4] == 2'h0 ? p[4] : 1'b1, x,
         s[0] ? x : p[1], s[1] ? x : p[0]};
   endfunction
   always @(posedge clk) begin
      if (!rstn) n_carry <= 8'h00;
      else if (carry === 1'b1) n_carry <= n_carry + 8'h01;
   end
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #100us;
      n_mismatch++;
      wrap_up();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {rstn, wr, bt, rd, evm, tick, bs, wd, addr} = '0;
      tma = '{`TMIR_TMC0_ADDR, `TMIR_TMC1_ADDR, `TMIR_TMC2_ADDR};
      iscs = '{6'h00, 6'h03, 6'h0B, 6'h23};
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rdc(`TMIR_ISC_ADDR, 8'h00);
      for (int c = 0; c < 3; c++) rdc(tma[c], 8'h00);
      rdc(16'hFF00, 8'h00);
      wrb(`TMIR_ISC_ADDR, 8'h2F, 1'b0, 3'h0);
      rdc(`TMIR_ISC_ADDR, 8'h2F);
      wrb(`TMIR_ISC_ADDR, 8'h00, 1'b1, 3'h5);
      rdc(`TMIR_ISC_ADDR, 8'h0F);
      for (int k = 0; k < 4; k++) begin
         wrb(`TMIR_ISC_ADDR, {2'h0, iscs[k]}, 1'b0, 3'h0);
         for (int p = 0; p < 32; p++) begin
            i_tmir_pins.drive(p[4:0], 1'b0);
            repeat (5) @(posedge clk);
            #1;
            chk({3'h0, txa, txd, rx, irq, cap}, route(iscs[k], p[4:0]));
         end
      end
      for (int c = 0; c < 3; c++) begin
         wrb(`TMIR_CMP0_ADDR + 16'(c), 8'h03, 1'b0, 3'h0);
         wrb(tma[c], 8'h02, 1'b0, 3'h0);
         wrb(tma[c], 8'h0A, 1'b0, 3'h0);
         rdc(tma[c], 8'h02);
         chk({7'h0, chout[c]}, 8'h01);
         wrb(tma[c], 8'h06, 1'b0, 3'h0);
         rdc(tma[c], 8'h02);
         chk({7'h0, chout[c]}, 8'h00);
         wrb(tma[c], 8'h80, 1'b1, 3'h7);
         rdc(tma[c], 8'h82);
         ticks(c, 5);
         repeat (3) @(posedge clk);
         rdc(`TMIR_CNT0_ADDR + 16'(c), 8'h01);
         chk({7'h0, chout[c]}, 8'h01);
         wrb(tma[c], 8'h00, 1'b1, 3'h7);
         rdc(`TMIR_CNT0_ADDR + 16'(c), 8'h00);
      end
      wrb(tma[0], 8'h00, 1'b0, 3'h0);
      wrb(tma[0], 8'h80, 1'b1, 3'h7);
      ticks(0, 5);
      repeat (3) @(posedge clk);
      rdc(`TMIR_CNT0_ADDR, 8'h01);
      chk({7'h0, chout[0]}, 8'h01);
      @(posedge clk) evm <= 1'b1;
      wrb(`TMIR_CMP2_ADDR, 8'hFF, 1'b0, 3'h0);
      wrb(tma[2], 8'h80, 1'b1, 3'h7);
      i_tmir_pins.events(3);
      rdc(`TMIR_CNT2_ADDR, 8'h03);
      wrb(`TMIR_ISC_ADDR, 8'h04, 1'b0, 3'h0);
      i_tmir_pins.events(2);
      rdc(`TMIR_CNT2_ADDR, 8'h03);
      i_tmir_pins.drive(5'h1F, 1'b1);
      i_tmir_pins.events(2);
      rdc(`TMIR_CNT2_ADDR, 8'h05);
      wrb(`TMIR_CMP2_ADDR, 8'h05, 1'b0, 3'h0);
      i_tmir_pins.events(1);
      repeat (4) @(posedge clk);
      chk(n_carry, 8'h01);
      rdc(`TMIR_CNT2_ADDR, 8'h00);
      wrap_up();
   end
endmodule // tmir_bench
